// File: core/dam_core.sv
// dram address multiplexer with refresh counter, output control and ahb-lite registers
`timescale 1ns/100ps
`default_nettype none
module dam_core
    import dam_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // system address side
    input  wire logic [8:0]  row_addr_in,
    input  wire logic [8:0]  col_addr_in,
    input  wire logic        bank_select_lo,
    input  wire logic        bank_select_hi,
    input  wire logic        address_latch_strobe,
    // system control side
    input  wire logic [2:0]  mode_select,
    input  wire logic        row_strobe_in,
    input  wire logic        row_col_sel,
    input  wire logic        write_strobe_in,
    input  wire logic        device_select_n,
    // refresh flag open-drain pin
    input  wire logic        refresh_flag_io_in,
    output logic             refresh_flag_io_out,
    output logic             refresh_flag_io_oe,
    // dram side
    output logic [8:0]       mux_address_out,
    output logic             mux_address_oe,
    output logic [3:0]       row_strobe_out_n,
    output logic             col_strobe_out_n,
    output logic             write_strobe_out_n,
    output logic             control_strong_oe,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    // ==============================
    // state
    typedef struct packed {
        logic [8:0]  row_lat;
        logic [8:0]  col_lat;
        logic [1:0]  bank_lat;
        logic [8:0]  cnt;
        logic [1:0]  eoc_sel;
        logic        refresh_request_line_act;
        logic [1:0]  react;
        logic        cs_act;
        logic        strong_hold;
        logic [8:0]  addr_q;
        logic        addr_oe;
        logic [3:0]  ras_n;
        logic        cas_n;
        logic        we_n;
        logic        ctrl_oe;
        logic        rf_oe;
        logic        dp_wr;
        logic [3:0]  dp_addr;
        logic [31:0] rdata;
    } dam_state_t;

    localparam dam_state_t DAM_STATE_RESET = '{
        row_lat: 9'h000, col_lat: 9'h000, bank_lat: 2'h0, cnt: 9'h000,
        eoc_sel: DAM_EOC_RESET, refresh_request_line_act: 1'b0, react: 2'h0, cs_act: 1'b0,
        strong_hold: 1'b0, addr_q: 9'h000, addr_oe: 1'b0, ras_n: 4'hf,
        cas_n: 1'b1, we_n: 1'b1, ctrl_oe: 1'b0, rf_oe: 1'b0, dp_wr: 1'b0,
        dp_addr: 4'h0, rdata: 32'h0000_0000
    };

    dam_state_t state_reg;
    dam_state_t state_next;

    // ==============================
    // combinational helpers
    logic [8:0] row_eff;
    logic [8:0] col_eff;
    logic [1:0] bank_eff;
    logic [8:0] eoc_val;
    logic       in_refresh;
    logic       refresh_request_line_start;
    logic       refreshing;
    logic       refresh_request_line_done;
    logic       eoc_hit;
    logic       ext_clear;
    logic       selected;
    logic       addr_phase;
    logic       sw_clear;
    logic [31:0] status_word;

    always_comb begin
        // fall-through while strobe high
        row_eff    = address_latch_strobe ? row_addr_in : state_reg.row_lat;
        col_eff    = address_latch_strobe ? col_addr_in : state_reg.col_lat;
        bank_eff   = address_latch_strobe ? {bank_select_hi, bank_select_lo}
                                          : state_reg.bank_lat;
        case (state_reg.eoc_sel)
            2'h0:    eoc_val = DAM_EOC_127;
            2'h1:    eoc_val = DAM_EOC_255;
            default: eoc_val = DAM_EOC_511;
        endcase
        in_refresh = !mode_select[2];
        refresh_request_line_start = in_refresh && !row_strobe_in;
        refreshing = refresh_request_line_start || state_reg.refresh_request_line_act;
        refresh_request_line_done  = state_reg.refresh_request_line_act && (row_strobe_in || mode_select[2]);
        eoc_hit    = (state_reg.cnt == eoc_val);
        ext_clear  = !refresh_flag_io_in && !state_reg.rf_oe;
        selected   = state_reg.cs_act && (state_reg.react == 2'h0);
        addr_phase = hsel && htrans[1] && hready;
        sw_clear   = state_reg.dp_wr && (state_reg.dp_addr == DAM_OFS_COUNT) && hwdata[0];
        status_word = 32'h0000_0000;
        status_word[8:0]            = state_reg.cnt;
        status_word[DAM_ST_EOC_BIT] = eoc_hit;
        status_word[DAM_ST_DRV_BIT] = state_reg.addr_oe;
        status_word[DAM_ST_RFA_BIT] = state_reg.refresh_request_line_act;
        status_word[DAM_ST_CSA_BIT] = selected;
    end

    // ==============================
    // next state
    always_comb begin
        state_next = state_reg;
        if (address_latch_strobe) begin
            state_next.row_lat  = row_addr_in;
            state_next.col_lat  = col_addr_in;
            state_next.bank_lat = {bank_select_hi, bank_select_lo};
        end
        // refresh cycle tracking and counting
        if (refresh_request_line_done) begin
            state_next.refresh_request_line_act = 1'b0;
            state_next.cnt      = state_reg.cnt + 9'h001;
        end else if (refresh_request_line_start) begin
            state_next.refresh_request_line_act = 1'b1;
        end
        if (ext_clear || sw_clear) begin
            state_next.cnt = 9'h000;
        end
        // end of count setup mode takes the bank inputs
        if (mode_select == DAM_MODE_SET_EOC) begin
            state_next.eoc_sel = {bank_select_hi, bank_select_lo};
        end else if (state_reg.dp_wr && state_reg.dp_addr == DAM_OFS_CONFIG) begin
            state_next.eoc_sel = hwdata[1:0];
        end
        // select and reactivation delay
        if (device_select_n) begin
            state_next.cs_act = 1'b0;
            state_next.react  = DAM_REACT_CYC;
        end else begin
            state_next.cs_act = 1'b1;
            if (state_reg.react != 2'h0) begin
                state_next.react = state_reg.react - 2'h1;
            end
        end
        state_next.strong_hold = state_reg.cs_act && device_select_n;
        // address path
        if (in_refresh) begin
            state_next.addr_q = state_reg.cnt;
        end else if (row_col_sel) begin
            state_next.addr_q = row_eff;
        end else begin
            state_next.addr_q = col_eff;
        end
        // row strobes
        if (in_refresh) begin
            state_next.ras_n = {4{row_strobe_in}};
        end else begin
            state_next.ras_n = 4'hf;
            state_next.ras_n[bank_eff] = row_strobe_in;
        end
        state_next.cas_n = in_refresh || row_col_sel || row_strobe_in;
        state_next.we_n  = write_strobe_in;
        // output enables
        if (refreshing) begin
            state_next.addr_oe = 1'b1;
            state_next.ctrl_oe = 1'b1;
        end else if (device_select_n) begin
            state_next.addr_oe = 1'b0;
            state_next.ctrl_oe = state_reg.cs_act;
        end else begin
            state_next.addr_oe = selected;
            state_next.ctrl_oe = selected;
        end
        if (!refreshing && !selected) begin
            state_next.ras_n = 4'hf;
            state_next.cas_n = 1'b1;
            state_next.we_n  = 1'b1;
        end
        // flag pin: low at end of count in mode 2, and in mode 0 only while the row strobe input is low
        state_next.rf_oe = 1'b0;
        if (mode_select == DAM_MODE_BURST) begin
            state_next.rf_oe = eoc_hit;
        end else if (mode_select == DAM_MODE_EXT_REFRESH_REQUEST_LINE) begin
            state_next.rf_oe = eoc_hit && !row_strobe_in;
        end
        // bus slave, zero wait
        state_next.dp_wr = addr_phase && hwrite;
        if (addr_phase) begin
            state_next.dp_addr = haddr[3:0];
            if (haddr[7:0] == {4'h0, DAM_OFS_CONFIG}) begin
                state_next.rdata = {30'h0000_0000, state_reg.eoc_sel};
            end else if (haddr[7:0] == {4'h0, DAM_OFS_STATUS}) begin
                state_next.rdata = status_word;
            end else if (haddr[7:0] == {4'h0, DAM_OFS_COUNT}) begin
                state_next.rdata = {23'h00_0000, state_reg.cnt};
            end else begin
                state_next.rdata = 32'h0000_0000;
            end
            if (haddr[31:4] != 28'h000_0000) begin
                state_next.dp_addr = 4'hc;
                state_next.dp_wr   = 1'b0;
            end
        end
    end

    // power-up and reset leave controls high, addresses floating
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= DAM_STATE_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ==============================
    // outputs
    assign mux_address_out     = state_reg.addr_q;
    assign mux_address_oe      = state_reg.addr_oe;
    assign row_strobe_out_n    = state_reg.ras_n;
    assign col_strobe_out_n    = state_reg.cas_n;
    assign write_strobe_out_n  = state_reg.we_n;
    assign control_strong_oe   = state_reg.ctrl_oe;
    assign refresh_flag_io_oe  = state_reg.rf_oe;
    // open-drain pin only ever sinks
    assign refresh_flag_io_out = 1'b0;
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign hrdata              = state_reg.rdata;

    // ==============================
    // assertions
    default clocking dam_cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    we_follow_a: assert property ($past(clk_en) |-> write_strobe_out_n == ($past(write_strobe_in)
        || (!$past(refreshing) && !$past(selected))))
        else $error("write strobe output does not follow input");
    addr_float_a: assert property ($past(clk_en) && $past(device_select_n) && !$past(refreshing)
        |-> !mux_address_oe)
        else $error("address outputs driven while deselected");
    ctrl_high_a: assert property ($past(clk_en) && !$past(refreshing) && !$past(selected)
        |-> row_strobe_out_n == 4'hf && col_strobe_out_n)
        else $error("control outputs not high while deselected");
    react_delay_a: assert property ((clk_en && !device_select_n && !refreshing)[*5]
        |-> mux_address_oe && control_strong_oe)
        else $error("outputs not driven after reselect delay");
    react_early_a: assert property ($past(clk_en) && $rose(state_reg.cs_act) && !$past(refreshing)
        |-> !mux_address_oe)
        else $error("outputs driven before reselect delay");
    refresh_drive_a: assert property ($past(clk_en) && $past(refreshing)
        |-> mux_address_oe && control_strong_oe)
        else $error("outputs released during refresh");
    count_wrap_a: assert property (clk_en && refresh_request_line_done && !ext_clear && !sw_clear
        && state_reg.cnt == DAM_EOC_511 |=> state_reg.cnt == 9'h000)
        else $error("refresh counter did not wrap from 511");
    count_inc_a: assert property (clk_en && refresh_request_line_done && !ext_clear && !sw_clear
        |=> state_reg.cnt == $past(state_reg.cnt) + 9'h001)
        else $error("refresh counter did not advance");
    count_clear_a: assert property (clk_en && ext_clear |=> state_reg.cnt == 9'h000)
        else $error("external flag low did not clear counter");
    flag_eoc_a: assert property (clk_en && mode_select == DAM_MODE_BURST && eoc_hit
        |=> refresh_flag_io_oe)
        else $error("end of count not flagged");
    bank_decode_a: assert property ($past(clk_en) && $past(mode_select[2]) && $past(selected)
        && !$past(row_strobe_in) |-> $countones(~row_strobe_out_n) == 1)
        else $error("bank decode not one-hot");
    row_mux_a: assert property (clk_en && mode_select[2] && row_col_sel && address_latch_strobe
        |=> mux_address_out == $past(row_addr_in))
        else $error("row address not presented");

    refresh_seen_c: cover property (clk_en && refresh_request_line_done);
    wrap_seen_c: cover property (clk_en && refresh_request_line_done && state_reg.cnt == DAM_EOC_511);
    reselect_c: cover property ($rose(state_reg.cs_act) ##[1:8] mux_address_oe);
    deselect_refresh_c: cover property (device_select_n && refreshing);

endmodule // dam_core
`default_nettype wire

// File: include/dam_pkg.sv
// constants for the dram address multiplexer, refresh counter and output control
package dam_pkg;
    // ==============================
    // register map
    localparam logic [3:0]  DAM_OFS_CONFIG = 4'h0;
    localparam logic [3:0]  DAM_OFS_STATUS = 4'h4;
    localparam logic [3:0]  DAM_OFS_COUNT  = 4'h8;
    localparam logic [1:0]  DAM_EOC_RESET  = 2'h0;
    localparam int          DAM_ST_EOC_BIT = 9;
    localparam int          DAM_ST_DRV_BIT = 10;
    localparam int          DAM_ST_RFA_BIT = 11;
    localparam int          DAM_ST_CSA_BIT = 12;
    // ==============================
    // end of count values
    localparam logic [8:0]  DAM_EOC_127    = 9'h07f;
    localparam logic [8:0]  DAM_EOC_255    = 9'h0ff;
    localparam logic [8:0]  DAM_EOC_511    = 9'h1ff;
    // ==============================
    // modes
    localparam logic [2:0]  DAM_MODE_EXT_REFRESH_REQUEST_LINE  = 3'h0;
    localparam logic [2:0]  DAM_MODE_AUTO_REFRESH_REQUEST_LINE = 3'h1;
    localparam logic [2:0]  DAM_MODE_BURST     = 3'h2;
    localparam logic [2:0]  DAM_MODE_SET_EOC   = 3'h7;
    // ==============================
    // timing
    localparam int          DAM_CLK_NS     = 20;
    localparam int          DAM_REACT_NS   = 50;
    localparam int          DAM_REACT_INT  = (DAM_REACT_NS + DAM_CLK_NS - 1) / DAM_CLK_NS;
    localparam logic [1:0]  DAM_REACT_CYC  = DAM_REACT_INT[1:0];
endpackage : dam_pkg

// File: testbench/dam_sys_model.sv
// system-side model of the open-collector refresh flag pin
`timescale 1ns/100ps
`default_nettype none
module dam_sys_model (
    // pin drivers
    input  wire logic flag_oe,
    input  wire logic ext_pull,
    // resolved pin level
    output logic      flag_level
);
    // ==============================
    // wire-and with pull-up: either side may sink the pin
    assign flag_level = ~(flag_oe | ext_pull);
endmodule // dam_sys_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the dram address multiplexer
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dam_pkg::*;
    logic        sys_clk, reset_n, clk_en, bank_select_lo, bank_select_hi, address_latch_strobe;
    logic [8:0]  row_addr_in, col_addr_in, mux_address_out;
    logic [2:0]  mode_select, hsize;
    logic        row_strobe_in, row_col_sel, write_strobe_in, device_select_n, ext_pull;
    logic        refresh_flag_io_in, refresh_flag_io_oe, mux_address_oe, col_strobe_out_n;
    logic        write_strobe_out_n, control_strong_oe, hsel, hwrite, hreadyout, hresp, refresh_flag_io_out;
    logic [3:0]  row_strobe_out_n;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    int          mismatches, cmp_count, k;

    dam_core i_dam_core (.sys_clk, .reset_n, .clk_en, .row_addr_in, .col_addr_in, .bank_select_lo,
        .bank_select_hi, .address_latch_strobe, .mode_select, .row_strobe_in, .row_col_sel,
        .write_strobe_in, .device_select_n, .refresh_flag_io_in, .refresh_flag_io_out,
        .refresh_flag_io_oe, .mux_address_out, .mux_address_oe, .row_strobe_out_n, .col_strobe_out_n,
        .write_strobe_out_n, .control_strong_oe, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata);
    dam_sys_model i_dam_sys_model (.flag_oe(refresh_flag_io_oe), .ext_pull, .flag_level(refresh_flag_io_in));

    // ==============================
    // common tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // bounded wait for hready; data taken at the falling edge before the rising edge that ends the phase
    task wait_ok(output logic [31:0] d);
        logic r;
        for (int i = 0; i < 20; i++) begin
            @(negedge sys_clk);
            r = hreadyout;
            d = hrdata;
            @(posedge sys_clk);
            if (r === 1'b1) return;
        end
        mismatches++;
        report_and_stop;
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ok(rd);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ok(rd);
    endtask
    task refresh_request_line(input logic [8:0] i, input logic [8:0] eoc);
        row_strobe_in <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(row_strobe_out_n, 32'h0000_0000);
        check(mux_address_out, i);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(refresh_flag_io_oe, i == eoc);
        @(posedge sys_clk);
        row_strobe_in <= 1'b1;
        cyc(2);
    endtask

    // ==============================
    // scenarios
    task t_reset;
        @(negedge sys_clk);
        check({mux_address_oe, control_strong_oe, row_strobe_out_n}, 32'h0000_000f);
        @(posedge sys_clk);
        bus(1'b0, {28'h0, DAM_OFS_CONFIG}, 32'h0, rdv);
        check(rdv[1:0], DAM_EOC_RESET);
        bus(1'b0, {28'h0, DAM_OFS_STATUS}, 32'h0, rdv);
        check(rdv[8:0], 32'h0000_0000);
        bus(1'b0, 32'h0000_0040, 32'h0, rdv);
        check(rdv, 32'h0000_0000);
        bus(1'b1, 32'h0000_0040, 32'h0000_0003, rdv);
        bus(1'b0, {28'h0, DAM_OFS_CONFIG}, 32'h0, rdv);
        check(rdv[1:0], DAM_EOC_RESET);
        check({hresp, refresh_flag_io_out}, 32'h0000_0000);
        $display("test reset done");
    endtask
    task t_select;
        mode_select <= 3'h4;
        device_select_n <= 1'b0;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
            @(negedge sys_clk);
        end while (mux_address_oe !== 1'b1 && k < 8);
        check(k >= 4 && k <= 5, 32'h0000_0001);
        @(posedge sys_clk);
        $display("test select done");
    endtask
    task t_latch;
        for (int b = 0; b < 4; b++) begin
            {bank_select_hi, bank_select_lo} <= 2'(b);
            address_latch_strobe <= 1'b1;
            row_addr_in <= 9'h1a0 + 9'(b);
            col_addr_in <= 9'h050 + 9'(b);
            row_col_sel <= 1'b1;
            write_strobe_in <= b[0];
            cyc(2);
            @(negedge sys_clk);
            check(mux_address_out, 9'h1a0 + 9'(b));
            check(write_strobe_out_n, b[0]);
            @(posedge sys_clk);
            address_latch_strobe <= 1'b0;
            @(posedge sys_clk);
            {bank_select_hi, bank_select_lo} <= ~2'(b);
            row_addr_in <= 9'h0f0;
            col_addr_in <= 9'h10f;
            cyc(2);
            @(negedge sys_clk);
            check(mux_address_out, 9'h1a0 + 9'(b));
            @(posedge sys_clk);
            row_col_sel <= 1'b0;
            row_strobe_in <= 1'b0;
            @(posedge sys_clk);
            @(negedge sys_clk);
            check(mux_address_out, 9'h050 + 9'(b));
            check(row_strobe_out_n, 4'(~(4'h1 << b)));
            @(posedge sys_clk);
            row_strobe_in <= 1'b1;
        end
        $display("test latch done");
    endtask
    task t_count;
        mode_select <= 3'h0;
        bus(1'b1, {28'h0, DAM_OFS_COUNT}, 32'h0000_0001, rdv);
        bus(1'b1, {28'h0, DAM_OFS_CONFIG}, 32'h0000_0001, rdv);
        for (int i = 0; i < 512; i++) begin
            refresh_request_line(9'(i), DAM_EOC_255);
            if (i == 254) begin
                mode_select <= DAM_MODE_BURST;
                cyc(2);
                @(negedge sys_clk);
                check(refresh_flag_io_oe, 32'h0000_0001);
                @(posedge sys_clk);
                mode_select <= DAM_MODE_EXT_REFRESH_REQUEST_LINE;
            end
        end
        bus(1'b0, {28'h0, DAM_OFS_COUNT}, 32'h0, rdv);
        check(rdv[8:0], 32'h0000_0000);
        for (int i = 0; i < 3; i++) refresh_request_line(9'(i), DAM_EOC_255);
        ext_pull <= 1'b1;
        @(posedge sys_clk);
        ext_pull <= 1'b0;
        cyc(2);
        bus(1'b0, {28'h0, DAM_OFS_COUNT}, 32'h0, rdv);
        check(rdv[8:0], 32'h0000_0000);
        $display("test count done");
    endtask
    task t_desel;
        mode_select <= 3'h4;
        device_select_n <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({mux_address_oe, control_strong_oe}, 32'h0000_0001);
        cyc(2);
        @(negedge sys_clk);
        check({mux_address_oe, control_strong_oe, row_strobe_out_n, col_strobe_out_n}, 32'h0000_001f);
        @(posedge sys_clk);
        mode_select <= 3'h0;
        @(posedge sys_clk);
        row_strobe_in <= 1'b0;
        cyc(2);
        @(negedge sys_clk);
        check({mux_address_oe, control_strong_oe}, 32'h0000_0003);
        @(posedge sys_clk);
        row_strobe_in <= 1'b1;
        mode_select <= 3'h4;
        cyc(4);
        @(negedge sys_clk);
        check(mux_address_oe, 32'h0000_0000);
        @(posedge sys_clk);
        $display("test deselect done");
    endtask
    task t_mode7;
        mode_select <= 3'h7;
        {bank_select_hi, bank_select_lo} <= 2'b10;
        cyc(2);
        bus(1'b0, {28'h0, DAM_OFS_CONFIG}, 32'h0, rdv);
        check(rdv[1:0], 32'h0000_0002);
        mode_select <= 3'h4;
        bus(1'b1, {28'h0, DAM_OFS_CONFIG}, 32'h0, rdv);
        bus(1'b0, {28'h0, DAM_OFS_CONFIG}, 32'h0, rdv);
        check(rdv[1:0], 32'h0000_0000);
        $display("test end-of-count select done");
    endtask

    // ==============================
    // clock, reset and sequence
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        {reset_n, bank_select_lo, bank_select_hi, address_latch_strobe, ext_pull, hsel, hwrite} = '0;
        {clk_en, row_strobe_in, row_col_sel, write_strobe_in, device_select_n} = '1;
        {row_addr_in, col_addr_in, haddr, hwdata, htrans} = '0;
        mode_select = 3'h4;
        hsize = 3'h2;
        cyc(3);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_select;
        t_latch;
        t_count;
        t_desel;
        t_select;
        t_mode7;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
